/* ict_channel_timing.v */
// two-channel disk cable port: legacy decode, timing registers and strobe control
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ict_defines.vh"

// Operation
// - two 16-bit read/write channel timing registers, primary and secondary, reset zero
// - timing registers steer cable strobe timing and data-port buffering
// - decode enable set claims command block 1f0-1f7 or 170-177
// - decode enable set also claims control address 3f6 or 376
// - decode works only while the I/O space enable bit is set
// - per-channel interface-off bits silence cable signals despite decode enable
// - drive-1 select clear shares timing; set sends drive 1 to slave timing
// - first ready sample 5, 4 or 3 clocks after strobe; code 11 reserved
// - recovery after last sample is 4, 3, 2 or 1 clocks
// - drive-1 DMA fast bit speeds only drive 1 DMA, not its PIO
// - prefetch/post enable lets data-port reads prefetch and writes post
// - ready sample enable decides if the drive's ready line is sampled
// - fast bank bit picks programmed timing for data-port accesses, else compatible
// - drive-0 DMA fast bit speeds only drive 0 DMA, not its PIO
module ict_channel_timing #(
  parameter [2:0] COMPAT_SAMPLE = `ICT_COMPAT_SAMPLE,
  parameter [2:0] COMPAT_RECOV = `ICT_COMPAT_RECOV
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [15:0] reg_rdata_o,
  input wire io_req_i,
  input wire io_dma_i,
  input wire io_dma_ch_i,
  input wire [15:0] io_addr_i,
  input wire io_wr_i,
  input wire [15:0] io_wdata_i,
  output wire io_ready_o,
  output wire io_claim_o,
  output wire io_done_o,
  output wire [15:0] io_rdata_o,
  output wire [1:0] cbl_ior_n_o,
  output wire [1:0] cbl_iow_n_o,
  output wire [1:0] cbl_cs0_n_o,
  output wire [1:0] cbl_cs1_n_o,
  output wire [1:0] cbl_dmack_n_o,
  output wire [5:0] cbl_da_o,
  output wire [31:0] cbl_dd_o,
  output wire [1:0] cbl_dd_oe_o,
  input wire [31:0] cbl_dd_i,
  input wire [1:0] cbl_iordy_i
);
  wire rst_n;
  reg [15:0] tim_pri_ff;
  reg [15:0] tim_sec_ff;
  reg [2:0] cfg_ff;
  reg [7:0] slv_ff;
  reg [15:0] reg_rdata_ff;
  reg [15:0] nxt_rdata;
  reg io_done_ff;
  reg [15:0] io_rdata_ff;
  wire [31:0] tim_all;
  wire [1:0] claim;
  wire [1:0] busy;
  wire [1:0] fin;
  wire [31:0] fin_data;
  wire [1:0] drv_sel;
  wire [1:0] pf_valid;

  ict_rst_sync u_rst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .rst_n_o(rst_n)
  );

  assign tim_all = {tim_sec_ff, tim_pri_ff};

  // register port
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tim_pri_ff <= `ICT_TIM_RESET;
      tim_sec_ff <= `ICT_TIM_RESET;
      cfg_ff <= `ICT_CFG_RESET;
      slv_ff <= `ICT_SLV_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ICT_OFS_PRI_TIM: tim_pri_ff <= reg_wdata_i & `ICT_TIM_WMASK;
        `ICT_OFS_SEC_TIM: tim_sec_ff <= reg_wdata_i & `ICT_TIM_WMASK;
        `ICT_OFS_CFG: cfg_ff <= reg_wdata_i[2:0];
        `ICT_OFS_SLV: slv_ff <= reg_wdata_i[7:0];
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `ICT_OFS_PRI_TIM: nxt_rdata = tim_pri_ff;
      `ICT_OFS_SEC_TIM: nxt_rdata = tim_sec_ff;
      `ICT_OFS_CFG: nxt_rdata = {13'h0, cfg_ff};
      `ICT_OFS_SLV: nxt_rdata = {8'h00, slv_ff};
      `ICT_OFS_STAT: nxt_rdata = {10'h0, drv_sel, pf_valid, busy};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 16'h0000;
      io_done_ff <= 1'b0;
      io_rdata_ff <= 16'h0000;
    end else begin
      reg_rdata_ff <= reg_rd_i ? nxt_rdata : 16'h0000;
      io_done_ff <= |fin;
      io_rdata_ff <= fin[1] ? fin_data[31:16] : fin_data[15:0];
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign io_done_o = io_done_ff;
  assign io_rdata_o = io_rdata_ff;
  assign io_claim_o = |claim;
  assign io_ready_o = ~|busy;

  // one copy of decode, strobe timer and prefetch holder per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      localparam [0:0] CHB = (ch == 1) ? 1'b1 : 1'b0;
      wire [15:0] tim = tim_all[16*ch +: 16];
      wire [3:0] slv = slv_ff[4*ch +: 4];
      wire off = cfg_ff[`ICT_CFG_PRI_OFF + ch];
      wire sel_cmd;
      wire sel_ctl;
      wire dec;
      wire dsel;
      wire acc;
      wire data_port;
      wire ppe;
      wire pf_hit;
      wire post;
      wire quick;
      wire host_go;
      wire pf_go;
      wire go;
      wire l_dma;
      wire l_data;
      reg fast;
      wire slave;
      wire [1:0] smp_code;
      wire [1:0] rec_code;
      reg [2:0] smp;
      reg [2:0] rec;
      wire rdy_en;
      wire strobe;
      wire smp_pulse;
      wire tmr_busy;
      reg drv_ff;
      reg pf_valid_ff;
      reg pf_pend_ff;
      reg [15:0] pf_data_ff;
      reg op_wr_ff;
      reg op_dma_ff;
      reg op_ctl_ff;
      reg op_data_ff;
      reg op_host_ff;
      reg [2:0] op_da_ff;
      reg [15:0] op_wdata_ff;
      reg [15:0] fin_word;

      assign sel_cmd = io_addr_i[15:3] == (ch == 0 ? `ICT_CMD_PRI : `ICT_CMD_SEC);
      assign sel_ctl = io_addr_i == (ch == 0 ? `ICT_CTL_PRI : `ICT_CTL_SEC);
      assign dec = cfg_ff[`ICT_CFG_IO_EN] & tim[`ICT_BIT_DECODE_EN] & !io_dma_i
                   & (sel_cmd | sel_ctl);
      assign dsel = io_dma_i & (io_dma_ch_i == CHB);
      assign claim[ch] = io_req_i & (dec | dsel);
      assign acc = claim[ch] & io_ready_o;
      assign data_port = sel_cmd & !io_dma_i & (io_addr_i[2:0] == `ICT_DATA_REG);
      assign ppe = drv_ff ? tim[`ICT_BIT_DRV1_PPE] : tim[`ICT_BIT_DRV0_PPE];

      // a prefetched word answers at once; a posted write is acknowledged before the cable
      assign pf_hit = acc & !off & data_port & !io_wr_i & pf_valid_ff & ppe;
      assign post = acc & !off & data_port & io_wr_i & ppe;
      assign quick = acc & (off | pf_hit | post);
      assign host_go = acc & !off & !pf_hit;
      assign pf_go = pf_pend_ff & !tmr_busy;
      assign go = host_go | pf_go;
      assign l_dma = host_go & io_dma_i;
      assign l_data = pf_go | (host_go & data_port);

      // timing pick for the cycle being launched
      always @* begin
        if (l_dma) begin
          fast = drv_ff ? tim[`ICT_BIT_DRV1_DMA_FAST] : tim[`ICT_BIT_DRV0_DMA_FAST];
        end else if (l_data) begin
          fast = drv_ff ? tim[`ICT_BIT_DRV1_BANK] : tim[`ICT_BIT_DRV0_BANK];
        end else begin
          fast = 1'b0;
        end
      end
      assign slave = drv_ff & tim[`ICT_BIT_DRV1_SEL];
      assign smp_code = slave ? slv[`ICT_SLV_SAMPLE] : tim[`ICT_FLD_SAMPLE];
      assign rec_code = slave ? slv[`ICT_SLV_RECOV] : tim[`ICT_FLD_RECOV];

      // the reserved sample code falls back to the shortest legal sample point
      always @* begin
        if (!fast) begin
          smp = COMPAT_SAMPLE;
        end else begin
          case (smp_code)
            2'b00: smp = `ICT_SAMPLE_C00;
            2'b01: smp = `ICT_SAMPLE_C01;
            default: smp = `ICT_SAMPLE_C10;
          endcase
        end
      end

      always @* begin
        if (!fast) begin
          rec = COMPAT_RECOV;
        end else begin
          rec = `ICT_RECOV_MAX - {1'b0, rec_code};
        end
      end
      assign rdy_en = drv_ff ? tim[`ICT_BIT_DRV1_RDY] : tim[`ICT_BIT_DRV0_RDY];

      ict_strobe_timer u_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .start_i(go),
        .sample_i(smp),
        .recov_i(rec),
        .rdy_en_i(rdy_en),
        .iordy_i(cbl_iordy_i[ch]),
        .strobe_o(strobe),
        .sample_o(smp_pulse),
        .busy_o(tmr_busy)
      );

      always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          drv_ff <= 1'b0;
          pf_valid_ff <= 1'b0;
          pf_pend_ff <= 1'b0;
          pf_data_ff <= 16'h0000;
          op_wr_ff <= 1'b0;
          op_dma_ff <= 1'b0;
          op_ctl_ff <= 1'b0;
          op_data_ff <= 1'b0;
          op_host_ff <= 1'b0;
          op_da_ff <= 3'h0;
          op_wdata_ff <= 16'h0000;
        end else begin
          if (acc & sel_cmd & io_wr_i & (io_addr_i[2:0] == `ICT_DEVHEAD_REG)) begin
            drv_ff <= io_wdata_i[`ICT_DRV_BIT];
          end
          if (go) begin
            op_wr_ff <= host_go & io_wr_i;
            op_dma_ff <= l_dma;
            op_ctl_ff <= host_go & !io_dma_i & sel_ctl;
            op_data_ff <= l_data;
            op_host_ff <= host_go & !post;
            op_da_ff <= (host_go & !io_dma_i) ? io_addr_i[2:0] : `ICT_DATA_REG;
            op_wdata_ff <= io_wdata_i;
          end
          if (smp_pulse & !op_host_ff & !op_wr_ff) begin
            pf_valid_ff <= 1'b1;
            pf_data_ff <= cbl_dd_i[16*ch +: 16];
          end else if (acc | !ppe) begin
            pf_valid_ff <= 1'b0;
          end
          if (off | !ppe) begin
            pf_pend_ff <= 1'b0;
          end else if (pf_hit | (smp_pulse & op_host_ff & op_data_ff & !op_wr_ff)) begin
            pf_pend_ff <= 1'b1;
          end else if (pf_go) begin
            pf_pend_ff <= 1'b0;
          end
        end
      end

      assign busy[ch] = tmr_busy | pf_pend_ff;
      assign drv_sel[ch] = drv_ff;
      assign pf_valid[ch] = pf_valid_ff;
      assign fin[ch] = quick | (smp_pulse & op_host_ff);
      always @* begin
        if (quick) begin
          fin_word = off ? `ICT_FLOAT_DATA : (pf_hit ? pf_data_ff : 16'h0000);
        end else begin
          fin_word = op_wr_ff ? 16'h0000 : cbl_dd_i[16*ch +: 16];
        end
      end
      assign fin_data[16*ch +: 16] = fin_word;

      // cable side, forced idle while the interface is off
      assign cbl_ior_n_o[ch] = !(strobe & !op_wr_ff & !off);
      assign cbl_iow_n_o[ch] = !(strobe & op_wr_ff & !off);
      assign cbl_cs0_n_o[ch] = !(tmr_busy & !op_dma_ff & !op_ctl_ff & !off);
      assign cbl_cs1_n_o[ch] = !(tmr_busy & !op_dma_ff & op_ctl_ff & !off);
      assign cbl_dmack_n_o[ch] = !(tmr_busy & op_dma_ff & !off);
      assign cbl_da_o[3*ch +: 3] = op_da_ff;
      assign cbl_dd_o[16*ch +: 16] = op_wdata_ff;
      assign cbl_dd_oe_o[ch] = tmr_busy & op_wr_ff & !off;
    end
  endgenerate
endmodule
`default_nettype wire

/* ict_defines.vh */
// register offsets, field positions, reset values and timing counts of the channel timing block
`ifndef ICT_DEFINES_VH
`define ICT_DEFINES_VH

`define ICT_OFS_PRI_TIM 8'h40
`define ICT_OFS_SEC_TIM 8'h42
`define ICT_OFS_CFG 8'h44
`define ICT_OFS_SLV 8'h46
`define ICT_OFS_STAT 8'h48

`define ICT_TIM_RESET 16'h0000
`define ICT_TIM_WMASK 16'hf3ff
`define ICT_CFG_RESET 3'h0
`define ICT_SLV_RESET 8'h00

`define ICT_BIT_DECODE_EN 15
`define ICT_BIT_DRV1_SEL 14
`define ICT_FLD_SAMPLE 13:12
`define ICT_FLD_RECOV 9:8
`define ICT_BIT_DRV1_DMA_FAST 7
`define ICT_BIT_DRV1_PPE 6
`define ICT_BIT_DRV1_RDY 5
`define ICT_BIT_DRV1_BANK 4
`define ICT_BIT_DRV0_DMA_FAST 3
`define ICT_BIT_DRV0_PPE 2
`define ICT_BIT_DRV0_RDY 1
`define ICT_BIT_DRV0_BANK 0

`define ICT_CFG_IO_EN 0
`define ICT_CFG_PRI_OFF 1
`define ICT_SLV_SAMPLE 3:2
`define ICT_SLV_RECOV 1:0

`define ICT_CMD_PRI 13'h003e
`define ICT_CMD_SEC 13'h002e
`define ICT_CTL_PRI 16'h03f6
`define ICT_CTL_SEC 16'h0376
`define ICT_DATA_REG 3'h0
`define ICT_DEVHEAD_REG 3'h6
`define ICT_DRV_BIT 4
`define ICT_FLOAT_DATA 16'hffff

`define ICT_SAMPLE_C00 3'd5
`define ICT_SAMPLE_C01 3'd4
`define ICT_SAMPLE_C10 3'd3
`define ICT_RECOV_MAX 3'd4
`define ICT_COMPAT_SAMPLE 3'd6
`define ICT_COMPAT_RECOV 3'd7

`endif

/* ict_rst_sync.v */
// reset release synchroniser
`timescale 1ns/100ps
`default_nettype none
module ict_rst_sync (
  input wire sys_clk_i,
  input wire rst_n_i,
  output wire rst_n_o
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      sync_ff <= meta_ff;
    end
  end

  assign rst_n_o = sync_ff;
endmodule
`default_nettype wire

/* ict_strobe_timer.v */
// read/write strobe timer: sample point, ready wait and recovery
`timescale 1ns/100ps
`default_nettype none
module ict_strobe_timer (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [2:0] sample_i,
  input wire [2:0] recov_i,
  input wire rdy_en_i,
  input wire iordy_i,
  output wire strobe_o,
  output wire sample_o,
  output wire busy_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_STROBE = 3'b010;
  localparam ST_RECOV = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg [2:0] smp_ff;
  reg [2:0] rec_ff;
  reg rdy_en_ff;

  // first sample once the strobe has been out smp_ff clocks; hold while the drive is not ready
  assign sample_o = state_ff[2'd1] && (cnt_ff >= smp_ff) && (!rdy_en_ff || iordy_i);
  assign strobe_o = state_ff[2'd1];
  assign busy_o = !state_ff[2'd0];

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff == 3'd7) ? cnt_ff : cnt_ff + 3'd1;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 3'd1;
        if (start_i) begin
          nxt_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (sample_o) begin
          nxt_state = ST_RECOV;
          nxt_cnt = 3'd1;
        end
      end
      ST_RECOV: begin
        if (cnt_ff >= rec_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'd1;
      smp_ff <= 3'd1;
      rec_ff <= 3'd1;
      rdy_en_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (start_i && state_ff[2'd0]) begin
        smp_ff <= sample_i;
        rec_ff <= recov_i;
        rdy_en_ff <= rdy_en_i;
      end
    end
  end
endmodule
`default_nettype wire

/* ict_drive_model.sv */
// drive pair model: returns a fixed word per channel and can hold ready low
`timescale 1ns/100ps
`default_nettype none
module ict_drive_model (
  input wire logic sys_clk_i,
  input wire logic [1:0] cbl_ior_n_o,
  input wire logic [1:0] cbl_iow_n_o,
  input wire logic [3:0] stall_i,
  output logic [31:0] cbl_dd_i,
  output logic [1:0] cbl_iordy_i
);
  wire logic [1:0] idle = cbl_ior_n_o & cbl_iow_n_o;
  logic [3:0] cnt_ff [2];
  always @(posedge sys_clk_i) begin
    for (int c = 0; c < 2; c++) begin
      cnt_ff[c] <= idle[c] ? 4'h0 : cnt_ff[c] + 4'h1;
    end
  end
  // ready is pulled up outside strobes; bus shows the inverted word when not read
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cbl_iordy_i[c] = idle[c] | (cnt_ff[c] >= stall_i);
      cbl_dd_i[16*c +: 16] = cbl_ior_n_o[c] ? ~{15'h2d18, c[0]} : {15'h2d18, c[0]};
    end
  end
endmodule
`default_nettype wire

/* ict_channel_timing_properties.sv */
// concurrent checks on the channel timing block ports
`timescale 1ns/100ps
`default_nettype none
module ict_channel_timing_properties (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic io_req_i,
  input wire logic io_dma_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_ready_o,
  input wire logic io_claim_o,
  input wire logic io_done_o,
  input wire logic [1:0] cbl_ior_n_o,
  input wire logic [1:0] cbl_iow_n_o,
  input wire logic [1:0] cbl_cs0_n_o,
  input wire logic [1:0] cbl_cs1_n_o,
  input wire logic [1:0] cbl_dmack_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside slot");
  a_rsvd_zero: assert property (
    $past(reg_rd_i) && $past(reg_addr_i[7:2]) == 6'h10 |-> reg_rdata_o[11:10] == 2'b00)
    else $error("reserved bits not zero");
  a_claim_range: assert property (
    io_req_i && !io_dma_i && io_addr_i[15:3] != 13'h003e && io_addr_i[15:3] != 13'h002e
    && io_addr_i != 16'h03f6 && io_addr_i != 16'h0376 |-> !io_claim_o)
    else $error("foreign address claimed");
  a_strobe_min: assert property (
    $fell(cbl_ior_n_o[0]) |-> !cbl_ior_n_o[0] [*3]) else $error("strobe too short");
  a_recov_gap: assert property (
    $rose(cbl_ior_n_o[0]) |=> cbl_ior_n_o[0] && cbl_iow_n_o[0]) else $error("no recovery");
  a_strobe_select: assert property (
    !cbl_ior_n_o[0] |-> !cbl_cs0_n_o[0] || !cbl_cs1_n_o[0] || !cbl_dmack_n_o[0])
    else $error("strobe without select");
  a_done_pulse: assert property (io_done_o |=> !io_done_o)
    else $error("done longer than one cycle");
  a_done_bound: assert property (
    io_req_i && io_claim_o && io_ready_o |=> ##[0:40] io_done_o) else $error("no done");
endmodule
bind ict_channel_timing ict_channel_timing_properties i_ict_channel_timing_properties (.*);
`default_nettype wire

/* ict_channel_timing_tb_top.sv */
// self-checking bench of the channel timing block
`timescale 1ns/100ps
`default_nettype none
`include "ict_defines.vh"
module ict_channel_timing_tb_top;
  logic sys_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, io_req_i = 0;
  logic io_dma_i = 0, io_wr_i = 0, io_ready_o, io_claim_o, io_done_o, cl, dn;
  logic [7:0] reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, io_addr_i = 0, reg_rdata_o, io_rdata_o, rdv, a;
  logic [1:0] cbl_ior_n_o, cbl_iow_n_o, cbl_cs0_n_o, cbl_iordy_i;
  logic [31:0] cbl_dd_i, seed = 32'h2a91, r;
  logic [3:0] stall_i = 0, dav;
  logic [5:0] cbl_da_o;
  logic [31:0] cbl_dd_o;
  logic [1:0] cbl_dd_oe_o;
  logic [15:0] wdv;
  logic [15:0] tbl [6] = '{16'h01f0, 16'h01f7, 16'h03f6, 16'h0177, 16'h0376, 16'h01f8};
  int n_mismatch = 0, checks = 0, cyc = 0, sl, rc;
  ict_channel_timing i_ict_channel_timing (.*, .io_dma_ch_i(1'b0), .io_wdata_i(16'h0010),
    .cbl_cs1_n_o(), .cbl_dmack_n_o());
  ict_drive_model i_ict_drive_model (.*);
  initial forever #50 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic claim_exp(input logic [15:0] x);
    return x[15:3] == 13'h003e || x[15:3] == 13'h002e || x == 16'h03f6 || x == 16'h0376;
  endfunction
  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rdv = reg_rdata_o;
  endtask
  // one host request; counts strobe cycles and the select-held recovery after it
  task automatic io(input logic [15:0] ad, input logic w, d);
    int t;
    t = 0;
    sl = 0;
    rc = 0;
    dav = 4'hf;
    wdv = 16'h0000;
    do begin
      @(negedge sys_clk_i);
      t++;
    end while (io_ready_o !== 1'b1 && t < 60);
    @(posedge sys_clk_i);
    io_req_i <= 1'b1;
    io_addr_i <= ad;
    io_wr_i <= w;
    io_dma_i <= d;
    @(negedge sys_clk_i);
    cl = io_claim_o;
    @(posedge sys_clk_i);
    io_req_i <= 1'b0;
    t = 0;
    do begin
      @(negedge sys_clk_i);
      t++;
      if (!(cbl_ior_n_o[0] && cbl_iow_n_o[0])) begin
        sl++;
        dav = {cbl_dd_oe_o[0], cbl_da_o[2:0]};
        wdv = cbl_dd_o[15:0];
      end
      dn = io_done_o;
      rdv = io_rdata_o;
    end while (dn !== 1'b1 && t < 60);
    while (cbl_cs0_n_o[0] === 1'b0 && t < 60) begin
      rc++;
      @(negedge sys_clk_i);
      t++;
    end
  endtask
  task automatic run_len(input logic [15:0] ad, input logic w, d, input int e);
    io(ad, w, d);
    chk_n(sl, e);
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 6; i++) begin
      rd(8'h40 + 8'(2 * i));
      chk_v(rdv, 16'h0000);
    end
    repeat (6) begin
      r = rnd();
      wr(8'h40, r[15:0]);
      wr(8'h42, r[31:16]);
      wr(8'h50, r[15:0]);
      rd(8'h40);
      chk_v(rdv, r[15:0] & `ICT_TIM_WMASK);
      rd(8'h42);
      chk_v(rdv, r[31:16] & `ICT_TIM_WMASK);
    end
    wr(8'h40, 16'h0000);
    wr(8'h42, 16'h0000);
    wr(8'h44, 16'h0001);
    io(16'h01f0, 1'b0, 1'b0);
    chk_v(16'(cl), 16'h0000);
    wr(8'h40, 16'h8000);
    wr(8'h42, 16'h8000);
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      a = (i < 6) ? tbl[i] : {6'h00, r[9:0]};
      io(a, 1'b0, 1'b0);
      chk_v(16'(cl), 16'(claim_exp(a)));
    end
    wr(8'h44, 16'h0000);
    io(16'h01f0, 1'b0, 1'b0);
    chk_v(16'(cl), 16'h0000);
    wr(8'h44, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        wr(8'h40, {2'b10, 2'(s), 2'b00, 2'(k), 8'h01});
        run_len(16'h01f0, 1'b0, 1'b0, (s == 3) ? 3 : 5 - s);
        chk_n(rc, 4 - k);
        chk_v(rdv, 16'h5a30);
      end
    end
    wr(8'h40, 16'h8001);
    run_len(16'h01f1, 1'b0, 1'b0, 6);
    chk_v(16'(dav), 16'h0001);
    wr(8'h40, 16'h8000);
    stall_i <= 4'h8;
    run_len(16'h01f0, 1'b0, 1'b0, 6);
    chk_n(rc, 7);
    wr(8'h40, 16'h8003);
    io(16'h01f0, 1'b0, 1'b0);
    chk_n(int'(sl >= 8), 1);
    stall_i <= 4'h0;
    wr(8'h40, 16'h9000);
    run_len(16'h0000, 1'b0, 1'b1, 6);
    wr(8'h40, 16'h9008);
    run_len(16'h0000, 1'b0, 1'b1, 4);
    run_len(16'h01f0, 1'b0, 1'b0, 6);
    wr(8'h40, 16'ha011);
    run_len(16'h01f6, 1'b1, 1'b0, 6);
    run_len(16'h01f0, 1'b0, 1'b0, 3);
    wr(8'h46, 16'h0000);
    wr(8'h40, 16'he011);
    run_len(16'h01f0, 1'b0, 1'b0, 5);
    wr(8'h40, 16'ha080);
    run_len(16'h0000, 1'b0, 1'b1, 3);
    run_len(16'h01f0, 1'b0, 1'b0, 6);
    wr(8'h40, 16'h8040);
    run_len(16'h01f0, 1'b0, 1'b0, 6);
    run_len(16'h01f0, 1'b0, 1'b0, 0);
    chk_v(rdv, 16'h5a30);
    run_len(16'h01f0, 1'b1, 1'b0, 1);
    chk_v(wdv, 16'h0010);
    chk_v(16'(dav), 16'h0008);
    wr(8'h44, 16'h0003);
    run_len(16'h01f0, 1'b0, 1'b0, 0);
    chk_v(rdv, `ICT_FLOAT_DATA);
    finish_test();
  end
endmodule
`default_nettype wire
